// >>> fwdt_regs.svh
`ifndef FWDT_REGS_SVH
`define FWDT_REGS_SVH

// Byte address of the control register on the bus
`define FWDT_CTRL_ADDR 8'h0c
// Field positions inside the control register
`define FWDT_ACT_BIT 7
`define FWDT_TOP_BIT 6
// Value after any reset: inactive, count all ones
`define FWDT_CTRL_RST 8'h7f
// Countdown value whose passing fires the reset
`define FWDT_FIRE_VAL 7'h40
// CPU cycles per countdown step
`define FWDT_DIV_CYCLES 49152
// CPU cycles from wake-up to counting again
`define FWDT_WAKE_CYCLES 4096
// Default length of the reset pulse in cycles
`define FWDT_RST_HOLD 64
// AHB transfer type and response codes
`define FWDT_HTRANS_NONSEQ 2'h2
`define FWDT_HTRANS_SEQ 2'h3
`define FWDT_HRESP_OKAY 1'h0

`endif

// >>> fwdt_pkg.sv
package fwdt_pkg;

    // Power state of the watchdog
    typedef enum logic [1:0] {
        FWDT_RUN,
        FWDT_HALTED,
        FWDT_WAKING,
        FWDT_FIRING
    } fwdt_state_t;

    // Width of the countdown value
    typedef logic [6:0] fwdt_count_t;

    // One bus data word
    typedef logic [31:0] fwdt_word_t;

endpackage : fwdt_pkg

// >>> fwdt_divider.sv
`timescale 1ns/1ns

// Fixed prescaler giving one enable pulse per period
module fwdt_divider #(
    parameter int unsigned DIV_CYCLES = 49152
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic clear_i,
    output logic tick_o
);

    // Wide enough for the default period
    logic [15:0] cnt_r;
    localparam logic [15:0] LAST = 16'(DIV_CYCLES - 1);

    // Prescaler count, frozen while not running
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 16'h0000;
        end else if (clear_i) begin
            cnt_r <= 16'h0000;
        end else if (run_i) begin
            // Wrap at the end of the period
            if (cnt_r == LAST) begin
                cnt_r <= 16'h0000;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // Registered step pulse, one cycle wide
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= run_i && !clear_i && (cnt_r == LAST);
        end
    end

endmodule : fwdt_divider

// >>> fwdt_watchdog.sv
`timescale 1ns/1ns
`include "fwdt_regs.svh"

module fwdt_watchdog #(
    parameter int unsigned DIV_CYCLES = `FWDT_DIV_CYCLES,
    parameter int unsigned RST_HOLD = `FWDT_RST_HOLD
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire fwdt_pkg::fwdt_word_t hwdata_i,
    input wire logic hready_i,
    output fwdt_pkg::fwdt_word_t hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Option settings, from pins
    input wire logic hw_watchdog_opt_i,
    input wire logic reset_on_halt_opt_i,
    // Core power events, same clock
    input wire logic halt_req_i,
    input wire logic wake_irq_i,
    // Reset request toward the reset pin
    output logic rst_req_b_o
);
    import fwdt_pkg::*;

    // Cycle count of the wake delay
    localparam logic [12:0] WAKE_LAST = 13'(`FWDT_WAKE_CYCLES - 1);
    // Cycle count of the reset pulse
    localparam logic [15:0] HOLD_LAST = 16'(RST_HOLD - 1);

    // Power and firing state
    fwdt_state_t state_r;
    fwdt_state_t state_nxt;
    // Activation bit
    logic activate_r;
    // Countdown value
    fwdt_count_t count_r;
    // Wake delay counter
    logic [12:0] wake_cnt_r;
    // Reset pulse counter
    logic [15:0] hold_cnt_r;
    // Option pin synchronisers
    logic [2:0] hw_sync_r;
    logic [2:0] hoh_sync_r;
    // Settled option levels
    logic hw_opt_r;
    logic hoh_opt_r;
    // Captured bus address phase
    logic wr_pend_r;
    // Step enable from the prescaler
    logic tick;
    // Watchdog may produce a reset
    logic active;
    // Bus write to the control register
    logic ctrl_wr;
    // Reset sources
    logic expire;
    logic sw_fire;
    logic halt_fire;
    logic fire;
    // Address phase hits the control register
    logic addr_hit;

    // Bus slave never stalls and never errors
    // Zero wait states keep the master side simple
    assign hreadyout_o = 1'b1;
    assign hresp_o = `FWDT_HRESP_OKAY;

    // Valid transfer to our word
    // Size is not decoded: every valid transfer acts as a word access
    assign addr_hit = hsel_i && hready_i && htrans_i[1] &&
                      (haddr_i[7:2] == 6'(`FWDT_CTRL_ADDR >> 2)) &&
                      (haddr_i[31:8] == 24'h000000);

    // Three-stage synchronisers on the option pins
    // Options are static in use; the extra stage filters glitches
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hw_sync_r <= 3'h0;
            hoh_sync_r <= 3'h0;
        end else begin
            hw_sync_r <= {hw_sync_r[1:0], hw_watchdog_opt_i};
            hoh_sync_r <= {hoh_sync_r[1:0], reset_on_halt_opt_i};
        end
    end

    // Accept an option change once two stages agree
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hw_opt_r <= 1'b0;
            hoh_opt_r <= 1'b0;
        end else begin
            if (hw_sync_r[2] == hw_sync_r[1]) begin
                hw_opt_r <= hw_sync_r[2];
            end
            if (hoh_sync_r[2] == hoh_sync_r[1]) begin
                hoh_opt_r <= hoh_sync_r[2];
            end
        end
    end

    // hardware option overrides
    // Activation bit is ignored when the option is set
    assign active = hw_opt_r || activate_r;

    // Write data phase follows the address phase
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_pend_r <= 1'b0;
        end else if (hready_i) begin
            wr_pend_r <= addr_hit && hwrite_i;
        end
    end

    // Writes during a firing pulse are dropped
    assign ctrl_wr = wr_pend_r && (state_r != FWDT_FIRING);

    // Prescaler runs only while counting
    // Clearing on a fire restarts the period with the reset count
    fwdt_divider #(
        .DIV_CYCLES(DIV_CYCLES)
    ) u_div (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .run_i(state_r == FWDT_RUN),
        .clear_i(fire),
        .tick_o(tick)
    );

    // expiry on top bit clearing
    // Only the 40h step clears the top bit by counting
    assign expire = (state_r == FWDT_RUN) && tick && !ctrl_wr &&
                    active && (count_r == `FWDT_FIRE_VAL);

    // software reset by write
    // Activation after this write counts, so a write setting it fires too
    assign sw_fire = ctrl_wr && !hwdata_i[`FWDT_TOP_BIT] &&
                     (active || hwdata_i[`FWDT_ACT_BIT]);

    // reset on halt instruction
    // Without the option a halt only freezes the counter
    assign halt_fire = (state_r == FWDT_RUN) && halt_req_i &&
                       hoh_opt_r && active;

    // single reset request
    // All sources merge into one request
    assign fire = (expire || sw_fire || halt_fire) && (state_r != FWDT_FIRING);

    // Activation bit
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            activate_r <= 1'b0;
        end else if (state_r == FWDT_FIRING) begin
            // reset state restored
            // The issued reset reinitialises the register too
            activate_r <= 1'b0;
        end else if (ctrl_wr && hwdata_i[`FWDT_ACT_BIT]) begin
            // set only, never cleared
            // Writing zero leaves an active watchdog active
            activate_r <= 1'b1;
        end
    end

    // Countdown value
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_r <= 7'(`FWDT_CTRL_RST);
        end else if (state_r == FWDT_FIRING) begin
            // Back to all ones with the issued reset
            count_r <= 7'(`FWDT_CTRL_RST);
        end else if (ctrl_wr) begin
            // Software reload wins over a step
            count_r <= hwdata_i[6:0];
        end else if (tick && (state_r == FWDT_RUN)) begin
            // Pulse from the last running cycle is dropped, else a
            // halt entered at 40h would slip past 3Fh with no reset
            // one step per period
            count_r <= count_r - 7'h01;
        end
    end

    // Read data registered in the address phase
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (hready_i) begin
            // control register layout
            // Unmapped words and upper bits read as zero
            if (addr_hit && !hwrite_i) begin
                hrdata_o <= {24'h000000, activate_r, count_r};
            end else begin
                hrdata_o <= 32'h0000_0000;
            end
        end
    end

    // Next power state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            FWDT_RUN: begin
                // wait mode ignored
                // Wait has no input here; counting goes on
                if (fire) begin
                    state_nxt = FWDT_FIRING;
                end else if (halt_req_i) begin
                    state_nxt = FWDT_HALTED;
                end
            end
            FWDT_HALTED: begin
                // An external interrupt, or a software reset write below, leaves halt here
                if (wake_irq_i) begin
                    state_nxt = FWDT_WAKING;
                end
            end
            FWDT_WAKING: begin
                if (sw_fire) begin
                    state_nxt = FWDT_FIRING;
                end else if (wake_cnt_r == WAKE_LAST) begin
                    state_nxt = FWDT_RUN;
                end
            end
            FWDT_FIRING: begin
                if (hold_cnt_r == HOLD_LAST) begin
                    state_nxt = FWDT_RUN;
                end
            end
        endcase
        // Software reset write is honoured while halted too
        if (state_r == FWDT_HALTED && sw_fire) begin
            state_nxt = FWDT_FIRING;
        end
    end

    // State register
    // Leaving halt by a reset lands in the running state
    // reset restores state
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= FWDT_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Wake delay counter, cleared outside the waking state
    // Thirteen bits hold the whole wake delay
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_cnt_r <= 13'h0000;
        end else if (state_r == FWDT_WAKING) begin
            wake_cnt_r <= wake_cnt_r + 13'h0001;
        end else begin
            wake_cnt_r <= 13'h0000;
        end
    end

    // Reset pulse counter
    // Limitation: a pulse length above 65536 cycles would wrap
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold_cnt_r <= 16'h0000;
        end else if (state_r == FWDT_FIRING) begin
            hold_cnt_r <= hold_cnt_r + 16'h0001;
        end else begin
            hold_cnt_r <= 16'h0000;
        end
    end

    // Registered request, low for the whole pulse
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_req_b_o <= 1'b1;
        end else begin
            rst_req_b_o <= (state_nxt != FWDT_FIRING);
        end
    end

endmodule : fwdt_watchdog

// >>> fwdt_chk_asserts.sv
`timescale 1ns/1ns
// Port-side checks of the fault timer
module fwdt_chk #(
    parameter int unsigned RST_HOLD = 64
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire fwdt_pkg::fwdt_word_t hwdata_i,
    input wire logic hready_i,
    input wire fwdt_pkg::fwdt_word_t hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic reset_on_halt_opt_i,
    input wire logic halt_req_i,
    input wire logic rst_req_b_o
);
    import fwdt_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic xfer; // Valid address phase
    logic rd_dp_r; // Data phase of a control read
    logic act_seen_r; // Activation seen, no fire since
    logic fresh_r; // Fired, not read back yet
    int unsigned low_cnt_r; // Cycles of the pulse so far
    assign xfer = hsel_i && hready_i && htrans_i[1];
    // Track read phases and pulse length
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_dp_r <= 1'b0;
            low_cnt_r <= 0;
        end else begin
            rd_dp_r <= xfer && !hwrite_i && haddr_i == 32'hc;
            low_cnt_r <= rst_req_b_o ? 0 : low_cnt_r + 1;
        end
    end
    // Flags cleared or set by a fire, so stale reads never count
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            act_seen_r <= 1'b0;
            fresh_r <= 1'b0;
        end else if (!rst_req_b_o) begin
            act_seen_r <= 1'b0;
            fresh_r <= 1'b1;
        end else if (rd_dp_r) begin
            act_seen_r <= act_seen_r | hrdata_o[7];
            fresh_r <= 1'b0;
        end else if (xfer && hwrite_i && haddr_i == 32'hc) begin
            // A write may set the activation bit again
            fresh_r <= 1'b0;
        end
    end
    sequence wr_ctrl;
        xfer && hwrite_i && haddr_i == 32'hc && rst_req_b_o;
    endsequence
    sequence fire_data;
        hwdata_i[7:6] == 2'b10 && rst_req_b_o;
    endsequence
    chk_pulse_len: assert property ($rose(rst_req_b_o) |-> low_cnt_r == RST_HOLD)
        else $error("Reset pulse length wrong");
    chk_sw_fire: assert property (wr_ctrl ##1 fire_data |-> ##[1:2] !rst_req_b_o)
        else $error("Software reset write ignored");
    chk_halt_fire: assert property (halt_req_i && reset_on_halt_opt_i && $past(reset_on_halt_opt_i, 4)
        && act_seen_r && rst_req_b_o |-> ##[1:2] !rst_req_b_o) else $error("Halt did not reset");
    chk_act_sticky: assert property (rd_dp_r && act_seen_r && rst_req_b_o && $past(rst_req_b_o)
        |-> hrdata_o[7]) else $error("Activation bit lost");
    chk_fire_clears: assert property (rd_dp_r && fresh_r && rst_req_b_o |-> !hrdata_o[7])
        else $error("Activation survived a fire");
    chk_read_top: assert property (rd_dp_r |-> hrdata_o[31:8] == 24'h0)
        else $error("Upper read bits not zero");
    chk_quiet_zero: assert property (!xfer || (!hwrite_i && haddr_i != 32'hc) |=> hrdata_o == 32'h0)
        else $error("Read data not zero");
    chk_bus_okay: assert property (hreadyout_o && hresp_o == 1'b0)
        else $error("Bus response not ready okay");
endmodule : fwdt_chk

bind fwdt_watchdog fwdt_chk #(.RST_HOLD(RST_HOLD)) u_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .reset_on_halt_opt_i(reset_on_halt_opt_i), .halt_req_i(halt_req_i), .rst_req_b_o(rst_req_b_o));

// >>> tb_top.sv
`timescale 1ns/1ns
// Register level test of the fault timer
module tb_top;
    import fwdt_pkg::*;
    localparam int DIV = 8; // Short prescaler
    localparam int HOLD = 4; // Short reset pulse
    localparam logic [31:0] CTRL = 32'hc;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    fwdt_word_t hwdata = 32'h0;
    fwdt_word_t hrdata, a, b;
    logic hready, hresp, rst_req_b;
    logic hw_opt = 1'b0;
    logic halt_opt = 1'b0;
    logic halt = 1'b0;
    logic wake = 1'b0;
    int fail_count = 0;
    int checks_done = 0;
    int fires = 0; // Reset pulses seen
    int n; // Cycles waited for a fire
    always #50 core_clk_i = ~core_clk_i;
    always @(negedge rst_req_b) fires++;
    fwdt_watchdog #(.DIV_CYCLES(DIV), .RST_HOLD(HOLD)) dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .hw_watchdog_opt_i(hw_opt), .reset_on_halt_opt_i(halt_opt), .halt_req_i(halt),
        .wake_irq_i(wake), .rst_req_b_o(rst_req_b));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One AHB single transfer; data taken at the closing edge
    task xfer(input logic w, input logic [31:0] ad, input logic [31:0] d, output fwdt_word_t q);
        @(posedge core_clk_i);
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        do @(posedge core_clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk_i); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer
    task wr(input logic [7:0] d);
        xfer(1'b1, CTRL, {24'h0, d}, b);
    endtask : wr
    // Count cycles until the next reset pulse, bounded
    task wait_fire(input int lim);
        int f;
        f = fires;
        n = 0;
        while (fires == f && n < lim) begin
            @(posedge core_clk_i);
            n++;
        end
    endtask : wait_fire
    task complete_run;
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        xfer(1'b0, CTRL, 32'h0, a);
        check(a, 32'h7f);
        xfer(1'b0, 32'h10, 32'h0, a);
        check(a, 32'h0);
        // Inactive counter runs past 40h quietly
        repeat (70 * DIV) @(posedge core_clk_i);
        xfer(1'b0, CTRL, 32'h0, a);
        check({a[7], a[6:0] < 7'h7f, fires == 0}, 3'b011);
        // Three steps from 42h to 3Fh
        wr(8'hc2);
        wait_fire(100);
        check(n >= 2 * DIV + 1 && n <= 3 * DIV + 3, 1'b1);
        repeat (HOLD + 2) @(posedge core_clk_i);
        xfer(1'b0, CTRL, 32'h0, a);
        check(a, 32'h7f);
        wr(8'hff);
        wr(8'h7f);
        xfer(1'b0, CTRL, 32'h0, a);
        check(a[7], 1'b1);
        wr(8'h80);
        wait_fire(10);
        check(n <= 3, 1'b1);
        repeat (HOLD + 2) @(posedge core_clk_i);
        // Halt freezes; wake resumes only after the delay
        wr(8'hff);
        halt <= 1'b1;
        @(posedge core_clk_i);
        halt <= 1'b0;
        xfer(1'b0, CTRL, 32'h0, a);
        repeat (5 * DIV) @(posedge core_clk_i);
        xfer(1'b0, CTRL, 32'h0, b);
        check(b, a);
        wake <= 1'b1;
        @(posedge core_clk_i);
        wake <= 1'b0;
        repeat (4000) @(posedge core_clk_i);
        xfer(1'b0, CTRL, 32'h0, b);
        check(b, a);
        repeat (120) @(posedge core_clk_i);
        xfer(1'b0, CTRL, 32'h0, b);
        check(a[6:0] - b[6:0] >= 2 && a[6:0] - b[6:0] <= 5, 1'b1);
        // Option turns halt into a reset
        halt_opt <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        wr(8'hff);
        halt <= 1'b1;
        @(posedge core_clk_i);
        halt <= 1'b0;
        wait_fire(10);
        check(n <= 3, 1'b1);
        halt_opt <= 1'b0;
        // Hardware option: active from reset, 64 steps
        hw_opt <= 1'b1;
        rst_b_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        wait_fire(700);
        check(n >= 64 * DIV - 8 && n <= 64 * DIV + 12, 1'b1);
        repeat (HOLD + 2) @(posedge core_clk_i);
        wr(8'h01);
        wait_fire(10);
        check(n <= 3, 1'b1);
        // Reset while halted: back to the running reset state
        repeat (HOLD + 2) @(posedge core_clk_i);
        halt <= 1'b1;
        @(posedge core_clk_i);
        halt <= 1'b0;
        repeat (2 * DIV) @(posedge core_clk_i);
        hw_opt <= 1'b0;
        rst_b_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        xfer(1'b0, CTRL, 32'h0, a);
        check(a, 32'h7f);
        repeat (3 * DIV) @(posedge core_clk_i);
        xfer(1'b0, CTRL, 32'h0, b);
        check(b[6:0] < 7'h7f, 1'b1);
        complete_run();
    end
    // Hang guard, well past the expected run
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fail_count++;
        complete_run();
    end
endmodule : tb_top
